/* logic/slow_consts.svh */
// Register map, field positions and sync-code constants for the line output writer
`ifndef SLOW_CONSTS_SVH
`define SLOW_CONSTS_SVH

`define SLOW_ADDR_W         8
`define SLOW_REG_CTRL       8'h00
`define SLOW_REG_BASE       8'h04
`define SLOW_REG_PITCH      8'h08
`define SLOW_REG_OFST       8'h0C
`define SLOW_REG_STAT       8'h10
`define SLOW_REG_LADDR      8'h14

`define SLOW_CTRL_WEN       0
`define SLOW_CTRL_PACK      1
`define SLOW_CTRL_ALAW      2
`define SLOW_CTRL_ESYNC     3
`define SLOW_CTRL_INP_LSB   4
`define SLOW_CTRL_DSZ_LSB   6
`define SLOW_CTRL_W         10
`define SLOW_CTRL_RESET     10'h000

`define SLOW_OFS_INV        0
`define SLOW_OFS_FOFS_LSB   1
`define SLOW_OFS_STEP_LSB   3
`define SLOW_OFS_STEP_W     3
`define SLOW_OFS_W          16
`define SLOW_OFS_RESET      16'h0000
`define SLOW_FOFS_ONE_LINE  2'h0

`define SLOW_ALIGN_BITS     5
`define SLOW_PITCH_W        16

`define SLOW_SY_DEN         16
`define SLOW_SY_HS          17
`define SLOW_SY_VS          18
`define SLOW_SY_FLD         19

`define SLOW_INP_RAW        2'h0
`define SLOW_INP_YUV16      2'h1
`define SLOW_INP_YUV8       2'h2

`define SLOW_DSZ_MAX_CODE   4'h8
`define SLOW_MASK_FULL      16'hFFFF
`define SLOW_MASK_BYTE      16'h00FF

`define SLOW_ES_PREAMBLE    8'hFF
`define SLOW_ES_ZERO        8'h00
`define SLOW_ES_BIT_H       4
`define SLOW_ES_BIT_V       5
`define SLOW_ES_BIT_F       6

`endif

/* logic/slow_pkg.sv */
// Types shared by the line output writer modules
package slow_pkg;

    typedef enum logic [1:0] {
        es_hunt = 2'b00,
        es_ff   = 2'b01,
        es_z1   = 2'b10,
        es_z2   = 2'b11
    } slow_es_state_e;

    typedef logic [31:0] slow_addr_t;

endpackage

/* logic/slow_sync_extract.sv */
// Embedded-sync code extractor: recovers line, frame and field timing from an 8-bit stream
`timescale 1ns/1ps
`include "slow_consts.svh"

module slow_sync_extract (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Byte stream
    input  wire logic       enable,
    input  wire logic [7:0] byte_in,
    // Recovered timing and pixels
    output logic            line_start,
    output logic            line_end,
    output logic            frame_start,
    output logic            field,
    output logic            vsync,
    output logic            pix_valid,
    output logic [7:0]      pix_data
);

    slow_pkg::slow_es_state_e state_q;
    logic             active_q;
    logic [3:0][7:0]  pd_q;
    logic [3:0]       pv_q;
    logic [3:0]       le_q;
    logic             hit;
    logic             sav;

    assign hit = enable && (state_q == slow_pkg::es_z2);
    assign sav = hit && !byte_in[`SLOW_ES_BIT_H] && !byte_in[`SLOW_ES_BIT_V];

    // Preamble hunter
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= slow_pkg::es_hunt;
        end else if (!enable) begin
            state_q <= slow_pkg::es_hunt;
        end else begin
            case (state_q)
                slow_pkg::es_hunt: state_q <= (byte_in == `SLOW_ES_PREAMBLE) ? slow_pkg::es_ff : slow_pkg::es_hunt;
                slow_pkg::es_ff: begin
                    if (byte_in == `SLOW_ES_ZERO)
                        state_q <= slow_pkg::es_z1;
                    else if (byte_in != `SLOW_ES_PREAMBLE)
                        state_q <= slow_pkg::es_hunt;
                end
                slow_pkg::es_z1:   state_q <= (byte_in == `SLOW_ES_ZERO) ? slow_pkg::es_z2 : slow_pkg::es_hunt;
                default:           state_q <= slow_pkg::es_hunt;
            endcase
        end
    end

    // Timing flags from the code word
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            active_q    <= 1'b0;
            vsync       <= 1'b0;
            field       <= 1'b0;
            line_start  <= 1'b0;
            frame_start <= 1'b0;
        end else begin
            line_start  <= sav;
            frame_start <= sav && vsync;
            if (!enable) begin
                active_q <= 1'b0;
            end else if (hit) begin
                active_q <= sav;
                vsync    <= byte_in[`SLOW_ES_BIT_V];
                field    <= byte_in[`SLOW_ES_BIT_F];
            end
        end
    end

    // Delay line so that preamble bytes already taken in as pixels can be struck out
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pd_q <= '0;
            pv_q <= 4'h0;
            le_q <= 4'h0;
        end else begin
            pd_q <= {pd_q[2:0], byte_in};
            pv_q <= {pv_q[2:0], active_q} & {4{!hit}};
            le_q <= {le_q[2:0], hit && byte_in[`SLOW_ES_BIT_H] && active_q};
        end
    end

    assign pix_valid = pv_q[3];
    assign pix_data  = pd_q[3];
    assign line_end  = le_q[3];

endmodule

/* logic/slow_line_writer.sv */
// Line output writer: turns pixel lines into addressed 32-bit memory writes
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "slow_consts.svh"

module slow_line_writer (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    // Register port
    input  wire logic [`SLOW_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    output logic      [31:0]             reg_rdata,
    // Sensor pins
    input  wire logic [15:0]             pin_data,
    input  wire logic                    pin_data_en,
    input  wire logic                    pin_hsync,
    input  wire logic                    pin_vsync,
    input  wire logic                    pin_field,
    // Memory write port
    output logic                         mem_wr_valid,
    output logic      [31:0]             mem_wr_addr,
    output logic      [31:0]             mem_wr_data,
    // Timing to later stages
    output logic                         ds_hsync,
    output logic                         ds_vsync,
    output logic                         ds_field,
    output logic                         yuv_mode
);

    localparam int PIN_W = 20;

    // Configuration
    logic [`SLOW_CTRL_W-1:0]   ctrl_q;
    slow_pkg::slow_addr_t      base_q;
    logic [`SLOW_PITCH_W-1:0]  pitch_q;
    logic [`SLOW_OFS_W-1:0]    ofst_q;

    // Pin synchronisers
    logic [PIN_W-1:0] sy1_q;
    logic [PIN_W-1:0] sy2_q;
    logic             hs_prev_q;
    logic             vs_prev_q;

    // Line and frame state
    logic                 frame_on_q;
    logic                 line_on_q;
    logic                 first_line_q;
    logic                 fld_eff_q;
    logic [15:0]          line_cnt_q;
    slow_pkg::slow_addr_t line_addr_q;
    slow_pkg::slow_addr_t col_addr_q;
    logic [31:0]          word_q;
    logic [1:0]           lane_q;

    // Embedded-sync extractor outputs
    logic       es_ls;
    logic       es_le;
    logic       es_fs;
    logic       es_fld;
    logic       es_vs;
    logic       es_pv;
    logic [7:0] es_pd;

    // Decoded controls
    logic       wen;
    logic       pack;
    logic       alaw;
    logic       esync;
    logic [1:0] inp;
    logic [3:0] dsz;
    logic       fld_inv;
    logic [1:0] fofs;

    assign wen     = ctrl_q[`SLOW_CTRL_WEN];
    assign pack    = ctrl_q[`SLOW_CTRL_PACK];
    assign alaw    = ctrl_q[`SLOW_CTRL_ALAW];
    assign esync   = ctrl_q[`SLOW_CTRL_ESYNC];
    assign inp     = ctrl_q[`SLOW_CTRL_INP_LSB +: 2];
    assign dsz     = ctrl_q[`SLOW_CTRL_DSZ_LSB +: 4];
    assign fld_inv = ofst_q[`SLOW_OFS_INV];
    assign fofs    = ofst_q[`SLOW_OFS_FOFS_LSB +: 2];

    // Register writes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q  <= `SLOW_CTRL_RESET;
            base_q  <= 32'h0000_0000;
            pitch_q <= 16'h0000;
            ofst_q  <= `SLOW_OFS_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                `SLOW_REG_CTRL:  ctrl_q  <= reg_wdata[`SLOW_CTRL_W-1:0];
                `SLOW_REG_BASE:  base_q  <= {reg_wdata[31:`SLOW_ALIGN_BITS], `SLOW_ALIGN_BITS'(0)};
                `SLOW_REG_PITCH: pitch_q <= {reg_wdata[`SLOW_PITCH_W-1:`SLOW_ALIGN_BITS], `SLOW_ALIGN_BITS'(0)};
                `SLOW_REG_OFST:  ofst_q  <= reg_wdata[`SLOW_OFS_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Register reads, data in the following cycle; unmapped reads give zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            case (reg_addr)
                `SLOW_REG_CTRL:  reg_rdata <= 32'(ctrl_q);
                `SLOW_REG_BASE:  reg_rdata <= base_q;
                `SLOW_REG_PITCH: reg_rdata <= 32'(pitch_q);
                `SLOW_REG_OFST:  reg_rdata <= 32'(ofst_q);
                `SLOW_REG_STAT:  reg_rdata <= {line_cnt_q, 11'h000, frame_on_q, ds_hsync, ds_vsync, fld_eff_q, yuv_mode};
                `SLOW_REG_LADDR: reg_rdata <= line_addr_q;
                default:         reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Two-stage pin capture; only the second stage is read
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sy1_q     <= '0;
            sy2_q     <= '0;
            hs_prev_q <= 1'b0;
            vs_prev_q <= 1'b0;
        end else begin
            sy1_q     <= {pin_field, pin_vsync, pin_hsync, pin_data_en, pin_data};
            sy2_q     <= sy1_q;
            hs_prev_q <= sy2_q[`SLOW_SY_HS];
            vs_prev_q <= sy2_q[`SLOW_SY_VS];
        end
    end

    slow_sync_extract u_sync_extract (
        .clock       (clock),
        .reset_n     (reset_n),
        .enable      (esync),
        .byte_in     (sy2_q[7:0]),
        .line_start  (es_ls),
        .line_end    (es_le),
        .frame_start (es_fs),
        .field       (es_fld),
        .vsync       (es_vs),
        .pix_valid   (es_pv),
        .pix_data    (es_pd)
    );

    // Source selection: embedded-sync feeds the same path as the pin timing
    logic        src_valid;
    logic [15:0] src_data;
    logic        ev_ls;
    logic        ev_le;
    logic        ev_fs;
    logic        src_fld;
    logic        src_hs;
    logic        src_vs;

    always_comb begin
        if (esync) begin
            src_valid = es_pv;
            src_data  = {8'h00, es_pd};
            ev_ls     = es_ls;
            ev_le     = es_le;
            ev_fs     = es_fs;
            src_fld   = es_fld;
            src_hs    = es_ls;
            src_vs    = es_vs;
        end else begin
            src_valid = sy2_q[`SLOW_SY_DEN] && sy2_q[`SLOW_SY_HS];
            src_data  = sy2_q[`SLOW_SY_DEN-1:0];
            ev_ls     = sy2_q[`SLOW_SY_HS] && !hs_prev_q;
            ev_le     = !sy2_q[`SLOW_SY_HS] && hs_prev_q;
            ev_fs     = sy2_q[`SLOW_SY_VS] && !vs_prev_q;
            src_fld   = sy2_q[`SLOW_SY_FLD];
            src_hs    = sy2_q[`SLOW_SY_HS];
            src_vs    = sy2_q[`SLOW_SY_VS];
        end
    end

    // Pixel width and packing
    logic        yuv_d;
    logic        eight_bit;
    logic        packed_mode;
    logic [3:0]  dsz_c;
    logic [15:0] pix_mask;
    logic [15:0] pix;

    always_comb begin
        yuv_d       = (inp == `SLOW_INP_YUV16) || (inp == `SLOW_INP_YUV8) || esync;
        dsz_c       = (dsz > `SLOW_DSZ_MAX_CODE) ? `SLOW_DSZ_MAX_CODE : dsz;
        eight_bit   = esync || (inp == `SLOW_INP_YUV8) || (!yuv_d && dsz_c == `SLOW_DSZ_MAX_CODE);
        packed_mode = pack && (eight_bit || alaw);
        if (yuv_d && !eight_bit)
            pix_mask = `SLOW_MASK_FULL;
        else if (eight_bit)
            pix_mask = `SLOW_MASK_BYTE;
        else
            pix_mask = `SLOW_MASK_FULL >> dsz_c;
        pix = src_data & pix_mask;
    end

    // Next word content; lanes fill from the low end
    logic [31:0] word_d;
    logic        word_full;

    always_comb begin
        if (packed_mode) begin
            word_d    = word_q | (32'(pix[7:0]) << {lane_q, 3'b000});
            word_full = (lane_q == 2'd3);
        end else begin
            word_d    = word_q | (32'(pix) << {lane_q[0], 4'b0000});
            word_full = lane_q[0];
        end
    end

    // Line stepping: code bit 2 is direction, bits 1:0 give lines minus one
    function automatic slow_pkg::slow_addr_t step_bytes(input logic [2:0] code, input logic [15:0] pitch);
        slow_pkg::slow_addr_t mag;
        mag = 32'h0000_0000;
        case (code[1:0])
            2'd0:    mag = 32'(pitch);
            2'd1:    mag = 32'(pitch) << 1;
            2'd2:    mag = 32'(pitch) + (32'(pitch) << 1);
            default: mag = 32'(pitch) << 2;
        endcase
        step_bytes = code[2] ? (32'h0000_0000 - mag) : mag;
    endfunction

    logic                 first;
    logic                 fld_now;
    logic [1:0]           step_sel;
    logic [2:0]           step_code;
    slow_pkg::slow_addr_t start_off;
    slow_pkg::slow_addr_t next_line_addr;

    always_comb begin
        first     = first_line_q || ev_fs;
        fld_now   = ev_fs ? (src_fld ^ fld_inv) : fld_eff_q;
        step_sel  = {fld_eff_q, line_cnt_q[0]};
        step_code = ofst_q[`SLOW_OFS_STEP_LSB + `SLOW_OFS_STEP_W * step_sel +: `SLOW_OFS_STEP_W];
        if (fofs == `SLOW_FOFS_ONE_LINE && fld_now)
            start_off = fld_inv ? (32'h0000_0000 - 32'(pitch_q)) : 32'(pitch_q);
        else
            start_off = 32'h0000_0000;
        if (first)
            next_line_addr = base_q + start_off;
        else
            next_line_addr = line_addr_q + step_bytes(step_code, pitch_q);
    end

    // Frame and line tracking
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            frame_on_q   <= 1'b0;
            line_on_q    <= 1'b0;
            first_line_q <= 1'b1;
            fld_eff_q    <= 1'b0;
            line_cnt_q   <= 16'h0000;
            line_addr_q  <= 32'h0000_0000;
        end else begin
            if (!wen) begin
                frame_on_q <= 1'b0;
            end else if (ev_fs) begin
                frame_on_q <= 1'b1;
            end
            if (ev_fs) begin
                first_line_q <= 1'b1;
                fld_eff_q    <= fld_now;
            end
            if (ev_ls && (frame_on_q || ev_fs) && wen) begin
                line_addr_q  <= next_line_addr;
                line_cnt_q   <= first ? 16'h0000 : line_cnt_q + 16'h0001;
                first_line_q <= 1'b0;
                line_on_q    <= 1'b1;
            end else if (ev_le || !wen) begin
                line_on_q <= 1'b0;
            end
        end
    end

    // Word assembly and memory writes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            col_addr_q   <= 32'h0000_0000;
            word_q       <= 32'h0000_0000;
            lane_q       <= 2'd0;
            mem_wr_valid <= 1'b0;
            mem_wr_addr  <= 32'h0000_0000;
            mem_wr_data  <= 32'h0000_0000;
        end else begin
            mem_wr_valid <= 1'b0;
            if (ev_ls && (frame_on_q || ev_fs) && wen) begin
                col_addr_q <= next_line_addr;
                word_q     <= 32'h0000_0000;
                lane_q     <= 2'd0;
            end else if (src_valid && line_on_q && wen) begin
                if (word_full) begin
                    mem_wr_valid <= 1'b1;
                    mem_wr_addr  <= col_addr_q;
                    mem_wr_data  <= word_d;
                    col_addr_q   <= col_addr_q + 32'h0000_0004;
                    word_q       <= 32'h0000_0000;
                    lane_q       <= 2'd0;
                end else begin
                    word_q <= word_d;
                    lane_q <= lane_q + 2'd1;
                end
            end else if (ev_le && line_on_q && wen && lane_q != 2'd0) begin
                // Partial word at line end goes out zero-filled
                mem_wr_valid <= 1'b1;
                mem_wr_addr  <= col_addr_q;
                mem_wr_data  <= word_q;
                col_addr_q   <= col_addr_q + 32'h0000_0004;
                word_q       <= 32'h0000_0000;
                lane_q       <= 2'd0;
            end
        end
    end

    // Timing outputs for later stages
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ds_hsync <= 1'b0;
            ds_vsync <= 1'b0;
            ds_field <= 1'b0;
            yuv_mode <= 1'b0;
        end else begin
            ds_hsync <= src_hs;
            ds_vsync <= src_vs;
            ds_field <= src_fld ^ fld_inv;
            yuv_mode <= yuv_d;
        end
    end

endmodule

/* verif/slow_mem_model.sv */
// Memory interconnect model that records every write of the line writer
`timescale 1ns/1ps

module slow_mem_model (
    // Clock
    input wire logic        clock,
    // Write port
    input wire logic        wr_valid,
    input wire logic [31:0] wr_addr,
    input wire logic [31:0] wr_data
);
    logic [31:0] wa[$];
    logic [31:0] wd[$];

    // Takes every pulse at once: the port has no backpressure
    always @(posedge clock) begin
        if (wr_valid === 1'b1) begin
            wa.push_back(wr_addr);
            wd.push_back(wr_data);
        end
    end
endmodule

/* verif/slow_line_writer_monitor.sv */
// Port checker for the line output writer
`timescale 1ns/1ps
`include "slow_consts.svh"

module slow_line_writer_monitor (
    // Clock and reset
    input wire logic                    clock,
    input wire logic                    reset_n,
    // Register port
    input wire logic [`SLOW_ADDR_W-1:0] reg_addr,
    input wire logic [31:0]             reg_wdata,
    input wire logic                    reg_write,
    input wire logic                    reg_read,
    input wire logic [31:0]             reg_rdata,
    // Memory port and mode
    input wire logic                    mem_wr_valid,
    input wire logic [31:0]             mem_wr_addr,
    input wire logic                    yuv_mode
);
    logic [`SLOW_CTRL_W-1:0] ctrl_q;
    logic                    yuv_exp;

    // Shadow of the control register as last written
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `SLOW_CTRL_RESET;
        end else if (reg_write && reg_addr == `SLOW_REG_CTRL) begin
            ctrl_q <= reg_wdata[`SLOW_CTRL_W-1:0];
        end
    end
    assign yuv_exp = ctrl_q[`SLOW_CTRL_ESYNC] || ctrl_q[5:4] == `SLOW_INP_YUV16 || ctrl_q[5:4] == `SLOW_INP_YUV8;

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside read cycle");
    a_write_needs_enable: assert property (mem_wr_valid |-> $past(ctrl_q[`SLOW_CTRL_WEN]))
        else $error("memory write while writes disabled");
    a_word_aligned: assert property (mem_wr_valid |-> mem_wr_addr[1:0] == 2'h0)
        else $error("memory write address not word aligned");
    a_column_step: assert property (mem_wr_valid && $past(mem_wr_valid, 2) |->
        mem_wr_addr == $past(mem_wr_addr, 2) + 32'h0000_0004)
        else $error("column address did not advance by one word");
    a_yuv_follows_ctrl: assert property ($stable(ctrl_q) [*3] |-> yuv_mode == yuv_exp)
        else $error("yuv mode does not match control setting");
    a_ctrl_readback: assert property (reg_read && reg_addr == `SLOW_REG_CTRL |=> reg_rdata == {22'h0, ctrl_q})
        else $error("control read back differs from written value");
    a_base_pitch_aligned: assert property (reg_read && (reg_addr == `SLOW_REG_BASE ||
        reg_addr == `SLOW_REG_PITCH) |=> reg_rdata[4:0] == 5'h00)
        else $error("base or pitch not 32-byte aligned");
    a_unmapped_zero: assert property (reg_read && reg_addr > `SLOW_REG_LADDR |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero");
    a_status_yuv: assert property (reg_read && reg_addr == `SLOW_REG_STAT |=> reg_rdata[0] == $past(yuv_mode))
        else $error("status yuv bit differs from yuv mode");
endmodule

bind slow_line_writer slow_line_writer_monitor u_mon (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr), .yuv_mode(yuv_mode)
);

/* verif/slow_line_writer_tb.sv */
// Self-checking testbench for the line output writer
`timescale 1ns/1ps
`include "slow_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; $display("MISMATCH at %0t: got %h expected %h", $time, (g), (e)); end end

module slow_line_writer_tb;
    localparam logic [31:0] BASE  = 32'h0000_1000;
    localparam logic [31:0] PITCH = 32'h0000_0040;
    logic        clock       = 1'b0;
    logic        reset_n     = 1'b0;
    logic [7:0]  reg_addr    = 8'h00;
    logic [31:0] reg_wdata   = 32'h0000_0000;
    logic        reg_write   = 1'b0;
    logic        reg_read    = 1'b0;
    logic [15:0] pin_data    = 16'h0000;
    logic        pin_data_en = 1'b0;
    logic        pin_hsync   = 1'b0;
    logic        pin_vsync   = 1'b0;
    logic        pin_field   = 1'b0;
    logic [31:0] reg_rdata, mem_wr_addr, mem_wr_data, rv;
    logic        mem_wr_valid, ds_hsync, ds_vsync, ds_field, yuv_mode;
    logic [15:0] m;
    logic [31:0] ctl[3];
    logic [31:0] dw[3];
    logic [7:0]  es[16];
    int          fails       = 0;
    int          checks_done = 0;

    always #4 clock = ~clock;

    slow_line_writer dut (
        .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .pin_data(pin_data), .pin_data_en(pin_data_en), .pin_hsync(pin_hsync),
        .pin_vsync(pin_vsync), .pin_field(pin_field), .mem_wr_valid(mem_wr_valid),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .ds_hsync(ds_hsync),
        .ds_vsync(ds_vsync), .ds_field(ds_field), .yuv_mode(yuv_mode)
    );

    slow_mem_model mem (.clock(clock), .wr_valid(mem_wr_valid), .wr_addr(mem_wr_addr), .wr_data(mem_wr_data));

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Field pin settles before the vsync rise that samples it
    task automatic start_frame(input logic f);
        mem.wa.delete();
        mem.wd.delete();
        @(posedge clock);
        pin_vsync <= 1'b0;
        pin_field <= f;
        repeat (4) @(posedge clock);
        pin_vsync <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    task automatic send_line(input int n, input logic [15:0] p);
        @(posedge clock);
        pin_hsync <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            pin_data_en <= 1'b1;
            pin_data    <= p + 16'(i);
        end
        @(posedge clock);
        pin_data_en <= 1'b0;
        pin_hsync   <= 1'b0;
        repeat (8) @(posedge clock);
    endtask

    task automatic run3(input logic f, input logic [31:0] a0, a1, a2);
        logic [31:0] ea[3];
        ea = '{a0, a1, a2};
        start_frame(f);
        for (int k = 0; k < 3; k++) send_line(2, 16'h0A00 + 16'(2 * k));
        `CHK(mem.wa.size(), 3)
        for (int k = 0; k < 3; k++) begin
            `CHK(mem.wa[k], ea[k])
            `CHK(mem.wd[k], {16'h0A01 + 16'(2 * k), 16'h0A00 + 16'(2 * k)})
        end
    endtask

    initial begin
        #400000;
        fails++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        rd(`SLOW_REG_CTRL, rv);
        `CHK(rv, 32'h0000_0000)
        rd(`SLOW_REG_OFST, rv);
        `CHK(rv, 32'h0000_0000)
        wr(`SLOW_REG_BASE, BASE | 32'h0000_0013);
        wr(`SLOW_REG_PITCH, PITCH | 32'h0000_0007);
        rd(`SLOW_REG_BASE, rv);
        `CHK(rv, BASE)
        rd(`SLOW_REG_PITCH, rv);
        `CHK(rv, PITCH)
        rd(8'h40, rv);
        `CHK(rv, 32'h0000_0000)
        @(posedge clock);
        pin_hsync <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK(ds_hsync, 1'b1)
        pin_hsync <= 1'b0;
        $display("Test registers done");
        // Steps: field0 even +2, field0 odd -2, field1 even +2, field1 odd +1
        wr(`SLOW_REG_OFST, 32'h0000_0348);
        start_frame(1'b0);
        send_line(2, 16'h0101);
        `CHK(mem.wa.size(), 0)
        wr(`SLOW_REG_CTRL, 32'h0000_0001);
        run3(1'b0, BASE, BASE + 2 * PITCH, BASE);
        `CHK(ds_field, 1'b0)
        `CHK(ds_vsync, 1'b1)
        run3(1'b1, BASE + PITCH, BASE + 3 * PITCH, BASE + 4 * PITCH);
        `CHK(ds_field, 1'b1)
        wr(`SLOW_REG_OFST, 32'h0000_0349);
        run3(1'b0, BASE - PITCH, BASE + PITCH, BASE + 2 * PITCH);
        `CHK(ds_field, 1'b1)
        $display("Test line addressing done");
        wr(`SLOW_REG_OFST, 32'h0000_0000);
        for (int c = 0; c < 10; c++) begin
            wr(`SLOW_REG_CTRL, 32'h0000_0001 | (32'(c) << 6));
            start_frame(1'b0);
            send_line(2, 16'hFFFE);
            m = 16'hFFFF >> (c > 8 ? 8 : c);
            `CHK(mem.wd[0], {m, m & 16'hFFFE})
        end
        $display("Test pixel width done");
        ctl = '{32'h0000_0203, 32'h0000_0007, 32'h0000_0011};
        dw  = '{32'h1413_1211, 32'h1413_1211, 32'h8012_8011};
        for (int i = 0; i < 3; i++) begin
            wr(`SLOW_REG_CTRL, ctl[i]);
            start_frame(1'b0);
            send_line(4, 16'h8011);
            `CHK(mem.wd[0], dw[i])
            `CHK(mem.wa.size(), (i == 2) ? 2 : 1)
        end
        $display("Test packing done");
        for (int f = 0; f < 5; f++) begin
            wr(`SLOW_REG_CTRL, (f == 4) ? 32'h0000_0008 : 32'(f) << 4);
            rd(`SLOW_REG_STAT, rv);
            `CHK(yuv_mode, 1'(f == 1 || f == 2 || f == 4))
            `CHK(rv[0], 1'(f == 1 || f == 2 || f == 4))
        end
        $display("Test input modes done");
        // Blanking code with V set, then active-line code, four pixels, end-of-line code
        es = '{8'hFF, 8'h00, 8'h00, 8'h20, 8'hFF, 8'h00, 8'h00, 8'h00,
               8'h11, 8'h22, 8'h33, 8'h44, 8'hFF, 8'h00, 8'h00, 8'h10};
        wr(`SLOW_REG_CTRL, 32'h0000_0009);
        mem.wa.delete();
        mem.wd.delete();
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            pin_data <= 16'(es[i]);
        end
        @(posedge clock);
        pin_data <= 16'h0000;
        repeat (12) @(posedge clock);
        `CHK(mem.wa.size(), 2)
        `CHK(mem.wa[0], BASE)
        `CHK(mem.wa[1], BASE + 32'h0000_0004)
        `CHK(mem.wd[0], 32'h0022_0011)
        `CHK(mem.wd[1], 32'h0044_0033)
        `CHK(ds_vsync, 1'b0)
        $display("Test embedded sync done");
        summarize();
    end
endmodule
